// File: rtl/rxp_pins.sv
// Reset and external memory bus pin control
// Behaviour
// - Pin low for 64 consecutive oscillator periods resets the device.
// - While pin low, port pins go to reset state at the next clock edge, before the reset filter fires.
// - Reset pin asserted in idle or power-down returns to normal operation.
// - Internal reset drives reset pin low for at least 12 periods.
// - Low address byte stands on the bus across the latch strobe falling edge.
// - Latch strobe toggles only for external move instruction accesses.
// - Read strobe asserted for the whole external data read.
// - Write strobe asserted for the whole external data write.
// - In slave port mode read and write strobes are host-driven inputs.
// - Low byte carries address/data, or slave low data in both modes.
// - Upper byte carries high address, or slave high data in 16-bit mode.
// - Program strobe is sampled as input during reset for programming detect.
// - Fetch select latched during reset, later changes ignored.
// - USB pull-up output floats while the disconnect bit is set.
// - During reset USB positive line high, negative line low.
`timescale 1ns/10ps
`include "rxp_map.svh"
module rxp_pins #(
   parameter int BYTE_W = 8
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // Reset pin (open drain) and internal reset sources
   input  wire logic              reset_pin_in,
   output logic                   reset_pin_out,
   output logic                   reset_pin_oe,
   input  wire logic              watchdog_reset,
   input  wire logic              power_monitor_reset,
   output logic                   device_reset,
   // Power state
   input  wire logic              idle_mode,
   input  wire logic              power_down_mode,
   output logic                   wake_normal,
   // Core external move request
   input  wire logic              xmove_req,
   input  wire logic              xmove_write,
   input  wire logic [15:0]       xmove_addr,
   input  wire logic [BYTE_W-1:0] xmove_wdata,
   output logic [BYTE_W-1:0]      xmove_rdata,
   output logic                   xmove_done,
   // Slave port configuration and core side
   input  wire logic              slave_mode,
   input  wire logic              slave_16bit,
   input  wire logic [15:0]       slave_rdata,
   output logic [15:0]            slave_wdata,
   output logic                   slave_rd_pulse,
   output logic                   slave_wr_pulse,
   // Low bus byte (two-way)
   input  wire logic [BYTE_W-1:0] ad_in,
   output logic [BYTE_W-1:0]      ad_out,
   output logic [BYTE_W-1:0]      ad_oe,
   // Upper bus byte (two-way)
   input  wire logic [BYTE_W-1:0] ah_in,
   output logic [BYTE_W-1:0]      ah_out,
   output logic [BYTE_W-1:0]      ah_oe,
   // Strobes
   input  wire logic              rd_in,
   output logic                   rd_out_n,
   output logic                   rd_oe,
   input  wire logic              wr_in,
   output logic                   wr_out_n,
   output logic                   wr_oe,
   output logic                   addr_latch,
   // Straps
   input  wire logic              program_strobe_in,
   output logic                   program_strobe_out,
   output logic                   program_strobe_oe,
   output logic                   in_system_programming,
   input  wire logic              external_fetch_select,
   output logic                   external_fetch_latched,
   // USB
   input  wire logic              usb_disconnect,
   output logic                   usb_pullup_out,
   output logic                   usb_pullup_oe,
   output logic                   usb_dp_out,
   output logic                   usb_dm_out,
   output logic                   usb_line_oe
);
   rxp_pkg::rxp_bus_state_e bus_state;
   logic                    ext_reset;
   logic [3:0]              out_cnt;
   logic                    internal_fire;
   logic                    in_reset;
   logic                    rd_prev;
   logic                    wr_prev;

   assign internal_fire = watchdog_reset | power_monitor_reset;
   // Raw pin low also counts as reset so ports fall back at the next clock, without waiting for the filter
   assign in_reset      = !reset_pin_in | ext_reset | device_reset;

   rxp_reset_detect #(
      .CNT_W (7)
   ) u_detect (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .pin_level (reset_pin_in),
      .reset_req (ext_reset)
   );

   // Reset pin pulldown stretched for internal resets
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_cnt       <= `RXP_OUT_ZERO;
         reset_pin_out <= 1'b0;
         reset_pin_oe  <= 1'b0;
      end else if (internal_fire) begin
         out_cnt      <= `RXP_RST_OUT_PERIODS;
         reset_pin_oe <= 1'b1;
      end else if (out_cnt != `RXP_OUT_ZERO) begin
         out_cnt      <= out_cnt - `RXP_OUT_ONE;
         reset_pin_oe <= out_cnt != `RXP_OUT_ONE;
      end else begin
         reset_pin_oe <= 1'b0;
      end
   end

   // Device reset and wake; pin drive from internal source is not self-sampled
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         device_reset <= 1'b1;
         wake_normal  <= 1'b0;
      end else begin
         device_reset <= ext_reset | internal_fire | (out_cnt != `RXP_OUT_ZERO);
         wake_normal  <= ext_reset & (idle_mode | power_down_mode);
      end
   end

   // Straps caught only while the device is really in reset, so a short reset pin glitch cannot relatch them
   // Program strobe is read only once our own drive of that pin has been released
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         in_system_programming  <= 1'b0;
         external_fetch_latched <= 1'b1;
      end else if (device_reset) begin
         external_fetch_latched <= external_fetch_select;
         if (!program_strobe_oe) begin
            in_system_programming <= !program_strobe_in;
         end
      end
   end

   // Program strobe released to input during reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         program_strobe_out <= 1'b1;
         program_strobe_oe  <= 1'b0;
      end else begin
         program_strobe_out <= 1'b1;
         program_strobe_oe  <= !in_reset;
      end
   end

   // USB pull-up and data line defaults
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         usb_pullup_out <= 1'b1;
         usb_pullup_oe  <= 1'b0;
         usb_dp_out     <= 1'b1;
         usb_dm_out     <= 1'b0;
         usb_line_oe    <= 1'b1;
      end else begin
         usb_pullup_out <= 1'b1;
         usb_pullup_oe  <= !usb_disconnect;
         usb_dp_out     <= 1'b1;
         usb_dm_out     <= 1'b0;
         usb_line_oe    <= in_reset;
      end
   end

   // External move sequencer: address, latch fall, strobe phase, done
   always_ff @(posedge core_clk) begin
      if (!rst_n || in_reset) begin
         bus_state   <= rxp_pkg::RXP_IDLE;
         addr_latch  <= 1'b0;
         rd_out_n    <= 1'b1;
         wr_out_n    <= 1'b1;
         rd_oe       <= 1'b0;
         wr_oe       <= 1'b0;
         ad_out      <= `RXP_PORT_RESET_BYTE;
         ad_oe       <= '0;
         ah_out      <= `RXP_PORT_RESET_BYTE;
         ah_oe       <= '0;
         xmove_done  <= 1'b0;
         xmove_rdata <= '0;
      end else begin
         xmove_done <= 1'b0;
         rd_oe      <= !slave_mode;
         wr_oe      <= !slave_mode;
         unique case (bus_state)
            rxp_pkg::RXP_IDLE: begin
               addr_latch <= 1'b0;
               if (slave_mode) begin
                  ad_out <= slave_rdata[7:0];
                  ad_oe  <= {BYTE_W{!rd_in}};
                  ah_out <= slave_rdata[15:8];
                  ah_oe  <= {BYTE_W{!rd_in & slave_16bit}};
               end else if (xmove_req) begin
                  ad_out     <= xmove_addr[7:0];
                  ad_oe      <= '1;
                  ah_out     <= xmove_addr[15:8];
                  ah_oe      <= '1;
                  addr_latch <= 1'b1;
                  bus_state  <= rxp_pkg::RXP_ADDR;
               end else begin
                  ad_oe <= '0;
                  ah_oe <= '0;
               end
            end
            rxp_pkg::RXP_ADDR: begin
               addr_latch <= 1'b0;
               if (xmove_write) begin
                  bus_state <= rxp_pkg::RXP_WRITE;
               end else begin
                  bus_state <= rxp_pkg::RXP_READ;
               end
            end
            rxp_pkg::RXP_READ: begin
               ad_oe     <= '0;
               rd_out_n  <= 1'b0;
               bus_state <= rxp_pkg::RXP_DONE;
            end
            rxp_pkg::RXP_WRITE: begin
               ad_out    <= xmove_wdata;
               wr_out_n  <= 1'b0;
               bus_state <= rxp_pkg::RXP_DONE;
            end
            rxp_pkg::RXP_DONE: begin
               if (!rd_out_n) begin
                  xmove_rdata <= ad_in;
               end
               rd_out_n   <= 1'b1;
               wr_out_n   <= 1'b1;
               ad_oe      <= '0;
               ah_oe      <= '0;
               xmove_done <= 1'b1;
               bus_state  <= rxp_pkg::RXP_IDLE;
            end
         endcase
      end
   end

   // Slave port: host strobes (active low) captured on their rising edge
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_prev        <= 1'b1;
         wr_prev        <= 1'b1;
         slave_rd_pulse <= 1'b0;
         slave_wr_pulse <= 1'b0;
         slave_wdata    <= '0;
      end else begin
         rd_prev        <= rd_in;
         wr_prev        <= wr_in;
         slave_rd_pulse <= slave_mode & !rd_prev & rd_in;
         slave_wr_pulse <= slave_mode & !wr_prev & wr_in;
         if (slave_mode && !wr_in) begin
            slave_wdata <= {(slave_16bit ? ah_in : 8'h00), ad_in};
         end
      end
   end
endmodule : rxp_pins

// File: rtl/rxp_map.svh
// Constants for the reset and external bus pin control block
`ifndef RXP_MAP_SVH
`define RXP_MAP_SVH
`define RXP_RST_LOW_PERIODS   7'h40
`define RXP_RST_OUT_PERIODS   4'hC
`define RXP_PORT_RESET_BYTE   8'hFF
`define RXP_CNT_ONE           7'h01
`define RXP_CNT_ZERO          7'h00
`define RXP_OUT_ONE           4'h1
`define RXP_OUT_ZERO          4'h0
`endif

// File: rtl/rxp_pkg.sv
// Types for the reset and external bus pin control block
package rxp_pkg;
   typedef enum logic [2:0] {
      RXP_IDLE,
      RXP_ADDR,
      RXP_READ,
      RXP_WRITE,
      RXP_DONE
   } rxp_bus_state_e;
   typedef enum logic [1:0] {
      RXP_RUN,
      RXP_IDLE_MODE,
      RXP_POWER_DOWN
   } rxp_power_e;
endpackage : rxp_pkg

// File: rtl/rxp_reset_detect.sv
// External reset pin filter: synchroniser and low-period counter
`timescale 1ns/10ps
`include "rxp_map.svh"
module rxp_reset_detect #(
   parameter int CNT_W = 7
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Pin and result
   input  wire logic pin_level,
   output logic      reset_req
);
   logic             sync_a;
   logic             sync_b;
   logic [CNT_W-1:0] low_cnt;

   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end else begin
         sync_a <= pin_level;
         sync_b <= sync_a;
      end
   end

   // Count consecutive low periods, restart on any high sample
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         low_cnt   <= `RXP_CNT_ZERO;
         reset_req <= 1'b0;
      end else if (sync_b) begin
         low_cnt   <= `RXP_CNT_ZERO;
         reset_req <= 1'b0;
      end else if (low_cnt != `RXP_RST_LOW_PERIODS) begin
         low_cnt   <= low_cnt + `RXP_CNT_ONE;
         reset_req <= (low_cnt + `RXP_CNT_ONE) == `RXP_RST_LOW_PERIODS;
      end else begin
         reset_req <= 1'b1;
      end
   end
endmodule : rxp_reset_detect

// File: test/rxp_pins_sva.sv
// Assertion checker for the reset and bus pin block
`timescale 1ns/10ps
module rxp_pins_sva (
   // Watched ports
   input wire logic        core_clk, rst_n, reset_pin_in, reset_pin_oe, watchdog_reset, device_reset,
   input wire logic        xmove_req, xmove_done, slave_mode, rd_out_n, rd_oe, wr_out_n, wr_oe, addr_latch,
   input wire logic        program_strobe_oe, external_fetch_latched, usb_disconnect, usb_pullup_oe,
   input wire logic        usb_dp_out, usb_dm_out, usb_line_oe,
   input wire logic [7:0]  ad_out, ad_oe, ah_out, xmove_wdata,
   input wire logic [15:0] xmove_addr
);
   logic [6:0] low_cnt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Run of low pin samples, saturating so a long hold never wraps to zero
   always_ff @(posedge core_clk) begin
      if (!rst_n || reset_pin_in) low_cnt <= 7'h00;
      else if (low_cnt != 7'h7F) low_cnt <= low_cnt + 7'h01;
   end
   a_ext_reset_entry: assert property (low_cnt == 7'h46 |-> device_reset)
      else $error("pin held low but no reset");
   a_port_reset_state: assert property (!reset_pin_in |=> ad_oe == 8'h00 && ad_out == 8'hFF)
      else $error("low bus not in reset state");
   a_int_reset_len: assert property (watchdog_reset |=> (device_reset && reset_pin_oe) [*8] ##1 reset_pin_oe [*4])
      else $error("reset pin pulse too short");
   a_addr_on_latch: assert property ($rose(addr_latch) |-> ad_oe == 8'hFF && ad_out == xmove_addr[7:0] &&
      ah_out == xmove_addr[15:8] ##1 !addr_latch)
      else $error("address not on bus at latch strobe");
   a_latch_only_move: assert property ($rose(addr_latch) |-> $past(xmove_req) && !slave_mode)
      else $error("latch strobe without external move");
   a_read_strobe: assert property ($fell(rd_out_n) |-> rd_oe && ad_oe == 8'h00 ##1 rd_out_n && xmove_done)
      else $error("read strobe window wrong");
   a_write_strobe: assert property ($fell(wr_out_n) |-> wr_oe && ad_out == xmove_wdata ##1 wr_out_n && xmove_done)
      else $error("write strobe window wrong");
   a_slave_strobes_in: assert property (slave_mode && $past(slave_mode) |-> !rd_oe && !wr_oe)
      else $error("strobes driven in slave mode");
   a_strap_sample: assert property (device_reset && $past(device_reset) |-> !program_strobe_oe)
      else $error("program strobe driven in reset");
   a_fetch_hold: assert property (!device_reset && !$past(device_reset) |-> $stable(external_fetch_latched))
      else $error("fetch select changed in operation");
   a_pullup_float: assert property (usb_disconnect |=> !usb_pullup_oe)
      else $error("pull-up driven while disconnected");
   a_usb_reset_lines: assert property (device_reset && $past(device_reset) |-> usb_line_oe && usb_dp_out && !usb_dm_out)
      else $error("usb lines wrong in reset");
   c_read: cover property ($fell(rd_out_n));
   c_write: cover property ($fell(wr_out_n));
   c_int_reset: cover property ($rose(reset_pin_oe));
endmodule : rxp_pins_sva
bind rxp_pins rxp_pins_sva i_rxp_pins_sva (.*);

// File: test/rxp_ext_mem.sv
// External data memory with its address latch on the low bus byte
`timescale 1ns/10ps
module rxp_ext_mem (
   // Bus pins as driven by the device
   input  wire logic       core_clk,
   input  wire logic       addr_latch,
   input  wire logic       rd_out_n,
   input  wire logic       wr_out_n,
   input  wire logic [7:0] ad_out,
   input  wire logic [7:0] ah_out,
   // Byte offered back on the low bus
   output logic      [7:0] mem_data
);
   logic [15:0] latched_addr = 16'h0000;
   logic [7:0]  mem [256];
   // Loaded on every clock edge while the strobe is high, so the value before its fall is held
   always @(posedge core_clk) if (addr_latch) latched_addr <= {ah_out, ad_out};
   // Write data is taken while the write strobe is low
   always @(posedge core_clk) if (!wr_out_n) mem[latched_addr[7:0]] <= ad_out;
   // Released bus shows the inverted byte so a stale value cannot pass as read data
   assign mem_data = rd_out_n ? ~mem[latched_addr[7:0]] : mem[latched_addr[7:0]];
endmodule : rxp_ext_mem

// File: test/rxp_pins_tb.sv
// Self-checking testbench for the reset and bus pin block
`timescale 1ns/10ps
module rxp_pins_tb;
   logic core_clk = 1'b0, rst_n = 1'b0, reset_pin_in, watchdog_reset, power_monitor_reset, idle_mode;
   logic power_down_mode, xmove_req, xmove_write, slave_mode, slave_16bit, rd_in, wr_in, program_strobe_in;
   logic external_fetch_select, usb_disconnect, reset_pin_out, reset_pin_oe, device_reset, wake_normal;
   logic xmove_done, slave_rd_pulse, slave_wr_pulse, rd_out_n, rd_oe, wr_out_n, wr_oe, addr_latch;
   logic program_strobe_out, program_strobe_oe, in_system_programming, external_fetch_latched;
   logic usb_pullup_out, usb_pullup_oe, usb_dp_out, usb_dm_out, usb_line_oe, host_rd_n, host_wr_n;
   logic [15:0] xmove_addr, slave_rdata, slave_wdata, host_data;
   logic [7:0]  xmove_wdata, xmove_rdata, ad_in, ad_out, ad_oe, ah_in, ah_out, ah_oe, mem_data, ref_mem [256];
   int          errors = 0, checks = 0, seed = 44709;
   // Wire levels: device drive wins per bit, else the memory or the host
   assign ad_in = (ad_oe & ad_out) | (~ad_oe & (slave_mode ? host_data[7:0] : mem_data));
   assign ah_in = (ah_oe & ah_out) | (~ah_oe & host_data[15:8]);
   assign rd_in = rd_oe ? rd_out_n : host_rd_n;
   assign wr_in = wr_oe ? wr_out_n : host_wr_n;
   rxp_pins i_rxp_pins (.*);
   rxp_ext_mem i_rxp_ext_mem (.*);
   always #50 core_clk = ~core_clk;
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d, errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic ticks(input int n);
      repeat (n) @(negedge core_clk);
   endtask : ticks
   // Expected drive of both bus bytes for a host read: upper byte only when wide
   function automatic logic [15:0] exp_oe(input logic wide);
      return {(wide ? 8'hFF : 8'h00), 8'hFF};
   endfunction : exp_oe
   // One external move; the request stands until the done pulse is seen
   task automatic xmove(input logic wr, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge core_clk);
      {xmove_write, xmove_addr, xmove_wdata, xmove_req} = {wr, a, d, 1'b1};
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (xmove_done !== 1'b1 && n < 10);
      chk("move_done", 16'(n), 16'h0004);
      @(negedge core_clk);
      xmove_req = 1'b0;
   endtask : xmove
   // Count high levels of a one-bit output at this and the following falling edges
   // Sampling starts now, so a level launched on the edge just passed is counted too
   task automatic count_high(input int span, ref logic sig, output int n);
      n = 0;
      repeat (span) begin
         n += sig;
         @(negedge core_clk);
      end
   endtask : count_high
   initial begin
      logic [15:0] a;
      logic [7:0]  d;
      int          n;
      {reset_pin_in, host_rd_n, host_wr_n, watchdog_reset, power_monitor_reset, idle_mode} = 6'h38;
      {power_down_mode, xmove_req, xmove_write, slave_mode, slave_16bit} = 5'h00;
      {program_strobe_in, external_fetch_select, usb_disconnect} = 3'h0;
      {xmove_addr, xmove_wdata, slave_rdata, host_data} = 56'h0;
      ticks(15);
      chk("usb_reset_lines", {usb_line_oe, usb_dp_out, usb_dm_out}, 16'h0006);
      ticks(1);
      rst_n = 1'b1;
      ticks(4);
      chk("isp_strap", in_system_programming, 16'h0001);
      external_fetch_select = 1'b1;
      ticks(3);
      chk("fetch_latched", external_fetch_latched, 16'h0000);
      // Back-to-back write and read, corners first, then random addresses
      for (int i = 0; i < 10; i++) begin
         a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($random(seed));
         d = 8'($random(seed));
         ref_mem[a[7:0]] = d;
         xmove(1'b1, a, d);
         xmove(1'b0, a, 8'h00);
         chk("read_data", xmove_rdata, ref_mem[a[7:0]]);
      end
      // Both internal sources give the same reset pin pulse
      for (int s = 0; s < 2; s++) begin
         {watchdog_reset, power_monitor_reset} = s ? 2'h1 : 2'h2;
         ticks(1);
         {watchdog_reset, power_monitor_reset} = 2'h0;
         count_high(20, reset_pin_oe, n);
         chk("reset_out_len", 16'(n), 16'h000C);
         ticks(4);
      end
      // Short low pulse must not reset; a long one from idle must
      idle_mode = 1'b1;
      reset_pin_in = 1'b0;
      ticks(40);
      reset_pin_in = 1'b1;
      ticks(3);
      chk("early_reset", device_reset, 16'h0000);
      reset_pin_in = 1'b0;
      ticks(2);
      chk("port_state", {ad_oe, ad_out}, 16'h00FF);
      ticks(68);
      chk("ext_reset", {device_reset, wake_normal}, 16'h0003);
      {idle_mode, power_down_mode} = 2'h1;
      ticks(2);
      chk("pd_wake", {wake_normal, reset_pin_out, program_strobe_oe}, 16'h0004);
      {reset_pin_in, power_down_mode} = 2'h2;
      ticks(6);
      chk("run_pins", {program_strobe_oe, program_strobe_out, usb_line_oe, usb_pullup_out}, 16'h000D);
      // Host read and write through the slave port
      {slave_mode, slave_16bit} = 2'h3;
      slave_rdata = 16'($random(seed));
      host_data = 16'($random(seed));
      host_rd_n = 1'b0;
      ticks(3);
      chk("slave_oe16", {ah_oe, ad_oe}, exp_oe(1'b1));
      chk("slave_read", {ah_out, ad_out}, slave_rdata);
      host_rd_n = 1'b1;
      host_wr_n = 1'b0;
      count_high(3, slave_rd_pulse, n);
      chk("slave_rd_pulses", 16'(n), 16'h0001);
      host_wr_n = 1'b1;
      count_high(4, slave_wr_pulse, n);
      chk("slave_write", slave_wdata, host_data);
      chk("slave_wr_pulses", 16'(n), 16'h0001);
      slave_16bit = 1'b0;
      host_rd_n = 1'b0;
      ticks(3);
      chk("slave_oe8", {ah_oe, ad_oe}, exp_oe(1'b0));
      {host_rd_n, slave_mode, usb_disconnect} = 3'h5;
      ticks(2);
      chk("pullup_float", usb_pullup_oe, 16'h0000);
      usb_disconnect = 1'b0;
      ticks(2);
      chk("pullup_drive", usb_pullup_oe, 16'h0001);
      finish_test();
   end
   // The run takes about 310 cycles, so 5000 cycles means a hang
   initial begin
      #500000;
      errors++;
      finish_test();
   end
endmodule : rxp_pins_tb
